// >>> hdl/sbas_pkg.sv
`default_nettype none
package sbas_pkg;
    localparam int VREG_WIDTH    = 64;
    localparam int VREG_ENTRIES  = 8;
    localparam int VREG_AW       = 3;
    localparam int LANE_WIDTH    = 8;
    localparam int LANE_COUNT    = 8;
    localparam int HALF_WIDTH    = 16;
    localparam int SCALAR_WIDTH  = 32;
    localparam int MEM_WIDTH_DEF = 64;
    localparam logic [VREG_WIDTH-1:0] VREG_RESET = 64'h0;
    localparam logic [SCALAR_WIDTH-1:0] RES_RESET = 32'h0;

    typedef enum logic [1:0] {
        SBAS_OP_NONE = 2'h0,
        SBAS_OP_VEC_ADD = 2'h1,
        SBAS_OP_HADD = 2'h3,
        SBAS_OP_HSUB = 2'h2
    } sbas_op_type;

    typedef struct packed {
        logic                     valid;
        sbas_op_type              op;
        logic [VREG_AW-1:0]       vdst;
        logic [VREG_AW-1:0]       vsrc0;
        logic [VREG_AW-1:0]       vsrc1;
        logic [SCALAR_WIDTH-1:0]  a;
        logic [SCALAR_WIDTH-1:0]  b;
    } sbas_issue_type;
endpackage
`default_nettype wire

// >>> hdl/sbas_top.sv
// Behaviour
// - An eight-entry register file of 64-bit vectors holds eight packed byte lanes each.
// - The vector byte add sums eight byte lanes in parallel with no carry between lanes.
// - Lane i sits at bits 8i+7 to 8i in sources and the result alike.
// - Load and store width is 32, 64 or 128 bits, a whole vector per access at 64 and up.
// - The halfword unit adds b with carry zero when add is high, else ~b with carry one.
// - Dual halfword add puts the low-lane sum in 15:0 and the high-lane sum in 31:16.
// - Dual halfword subtract uses the same two units with add low, high over low.
// - One low and one high unit are shared by both halfword instructions, muxed by opcode.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// One halfword add/subtract unit
module sbas_halfword_addsub_fn
    import sbas_pkg::*;
#(
    parameter int WIDTH = HALF_WIDTH
) (
    input  wire logic [WIDTH-1:0] i_a,
    input  wire logic [WIDTH-1:0] i_b,
    input  wire logic             i_add,
    output logic      [WIDTH-1:0] o_res
);
    logic [WIDTH-1:0] b_eff;
    logic             cin;

    // Subtract as add of the inverse, so one adder serves both
    always_comb begin
        b_eff = i_add ? i_b : ~i_b;
        cin   = ~i_add;
        o_res = i_a + b_eff + {{(WIDTH-1){1'b0}}, cin};
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sbas_top
    import sbas_pkg::*;
#(
    parameter int MEM_WIDTH = MEM_WIDTH_DEF
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire sbas_issue_type          i_issue,
    input  wire logic                    i_commit,
    input  wire logic                    i_mem_load,
    input  wire logic [VREG_AW-1:0]      i_mem_reg,
    input  wire logic [MEM_WIDTH-1:0]    i_mem_rdata,
    output logic [MEM_WIDTH-1:0]         o_mem_wdata,
    output logic [SCALAR_WIDTH-1:0]      o_res,
    output logic                         o_res_valid,
    output logic [VREG_WIDTH-1:0]        o_vsum
);
    localparam int BEATS = (MEM_WIDTH >= VREG_WIDTH) ? 1 : VREG_WIDTH / MEM_WIDTH;

    ////////////////////////////////////////////////////////////////////////////////
    // Shared halfword units
    logic                    hadd_sel;
    logic [HALF_WIDTH-1:0]   lo_res;
    logic [HALF_WIDTH-1:0]   hi_res;

    // Only halfword add raises the select; subtract, vector add and idle leave it low
    always_comb begin
        hadd_sel = (i_issue.op == SBAS_OP_HADD);
    end

    // One unit per lane, both opcodes steered through it
    sbas_halfword_addsub_fn #(
        .WIDTH (HALF_WIDTH)
    ) shared_lane_low_unit (
        .i_a   (i_issue.a[HALF_WIDTH-1:0]),
        .i_b   (i_issue.b[HALF_WIDTH-1:0]),
        .i_add (hadd_sel),
        .o_res (lo_res)
    );

    sbas_halfword_addsub_fn #(
        .WIDTH (HALF_WIDTH)
    ) shared_lane_high_unit (
        .i_a   (i_issue.a[SCALAR_WIDTH-1:HALF_WIDTH]),
        .i_b   (i_issue.b[SCALAR_WIDTH-1:HALF_WIDTH]),
        .i_add (hadd_sel),
        .o_res (hi_res)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Vector register file and byte adder
    logic [VREG_WIDTH-1:0] vreg_q [VREG_ENTRIES];
    logic [VREG_WIDTH-1:0] vreg_d [VREG_ENTRIES];
    logic [VREG_WIDTH-1:0] vsum;
    logic [VREG_WIDTH-1:0] va;
    logic [VREG_WIDTH-1:0] vb;

    always_comb begin
        va = vreg_q[i_issue.vsrc0];
        vb = vreg_q[i_issue.vsrc1];
        for (int i = 0; i < LANE_COUNT; i++) begin
            // Truncation drops lane carry by construction
            vsum[i*LANE_WIDTH +: LANE_WIDTH] = va[i*LANE_WIDTH +: LANE_WIDTH]
                                             + vb[i*LANE_WIDTH +: LANE_WIDTH];
        end
    end

    // Narrow memory paths need several beats; wide ones move a vector at once
    logic [$clog2(BEATS+1)-1:0] beat_q;
    logic [$clog2(BEATS+1)-1:0] beat_d;
    logic [VREG_WIDTH-1:0]      load_vec;

    // Split at elaboration so no slice runs past the vector
    generate
        if (BEATS == 1) begin : g_wide
            always_comb begin
                load_vec                    = i_mem_rdata[VREG_WIDTH-1:0];
                o_mem_wdata                 = '0;
                o_mem_wdata[VREG_WIDTH-1:0] = vreg_q[i_mem_reg];
            end

            wide_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
                i_mem_load |=> vreg_q[$past(i_mem_reg)] == $past(i_mem_rdata[VREG_WIDTH-1:0]))
                else $error("whole vector load missing");
        end else begin : g_narrow
            // Only loads advance the beat, so stores follow the last load
            always_comb begin
                load_vec = vreg_q[i_mem_reg];
                load_vec[beat_q*MEM_WIDTH +: MEM_WIDTH] = i_mem_rdata;
                o_mem_wdata = vreg_q[i_mem_reg][beat_q*MEM_WIDTH +: MEM_WIDTH];
            end
        end
    endgenerate

    always_comb begin
        for (int e = 0; e < VREG_ENTRIES; e++) begin
            vreg_d[e] = vreg_q[e];
        end
        beat_d = beat_q;
        if (i_commit && i_issue.valid && i_issue.op == SBAS_OP_VEC_ADD) begin
            vreg_d[i_issue.vdst] = vsum;
        end
        // Load last, so it wins over a same-cycle vector add
        if (i_mem_load) begin
            vreg_d[i_mem_reg] = load_vec;
            if (BEATS > 1) begin
                beat_d = (beat_q == BEATS - 1) ? '0 : beat_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Scalar result, valid flag and vector sum registers
    logic [SCALAR_WIDTH-1:0] res_q;
    logic [SCALAR_WIDTH-1:0] res_d;
    logic                    rv_q;
    logic                    rv_d;
    logic [VREG_WIDTH-1:0]   vsum_q;
    logic [VREG_WIDTH-1:0]   vsum_d;
    logic                    is_half;

    always_comb begin
        is_half = i_issue.op == SBAS_OP_HADD || i_issue.op == SBAS_OP_HSUB;
        res_d   = res_q;
        vsum_d  = vsum_q;
        rv_d    = i_commit && i_issue.valid && i_issue.op != SBAS_OP_NONE;
        if (i_commit && i_issue.valid && is_half) begin
            res_d = {hi_res, lo_res};
        end
        if (i_commit && i_issue.valid && i_issue.op == SBAS_OP_VEC_ADD) begin
            vsum_d = vsum;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int e = 0; e < VREG_ENTRIES; e++) begin
                vreg_q[e] <= VREG_RESET;
            end
            beat_q <= '0;
            res_q  <= RES_RESET;
            rv_q   <= 1'b0;
            vsum_q <= VREG_RESET;
        end else begin
            vreg_q <= vreg_d;
            beat_q <= beat_d;
            res_q  <= res_d;
            rv_q   <= rv_d;
            vsum_q <= vsum_d;
        end
    end

    assign o_res       = res_q;
    assign o_res_valid = rv_q;
    assign o_vsum      = vsum_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    logic com;
    assign com = i_commit && i_issue.valid;

    hadd_pack_a: assert property (@(posedge i_clk) disable iff (i_rst)
        com && i_issue.op == SBAS_OP_HADD |=> o_res ==
        {$past(i_issue.a[31:16]) + $past(i_issue.b[31:16]),
         $past(i_issue.a[15:0]) + $past(i_issue.b[15:0])})
        else $error("halfword add result wrong");
    hsub_pack_a: assert property (@(posedge i_clk) disable iff (i_rst)
        com && i_issue.op == SBAS_OP_HSUB |=> o_res ==
        {$past(i_issue.a[31:16]) - $past(i_issue.b[31:16]),
         $past(i_issue.a[15:0]) - $past(i_issue.b[15:0])})
        else $error("halfword subtract result wrong");
    sel_carry_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_issue.op == SBAS_OP_HADD) ?
            (16'(lo_res - i_issue.b[15:0]) == i_issue.a[15:0]) :
            (16'(lo_res + i_issue.b[15:0]) == i_issue.a[15:0]))
        else $error("low unit select or carry wrong");
    shared_mux_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_issue.op == SBAS_OP_HADD) ?
            (16'(hi_res - i_issue.b[31:16]) == i_issue.a[31:16]) :
            (16'(hi_res + i_issue.b[31:16]) == i_issue.a[31:16]))
        else $error("high unit operand mux wrong");
    lane0_sum_a: assert property (@(posedge i_clk) disable iff (i_rst)
        com && i_issue.op == SBAS_OP_VEC_ADD |=> o_vsum[7:0] ==
        8'($past(va[7:0]) + $past(vb[7:0])))
        else $error("lane zero sum wrong");
    lane7_sum_a: assert property (@(posedge i_clk) disable iff (i_rst)
        com && i_issue.op == SBAS_OP_VEC_ADD |=> o_vsum[63:56] ==
        8'($past(va[63:56]) + $past(vb[63:56])))
        else $error("lane seven sum wrong");
    vreg_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
        com && i_issue.op == SBAS_OP_VEC_ADD && !i_mem_load
        |=> vreg_q[$past(i_issue.vdst)] == o_vsum)
        else $error("vector write back missing");
    one_cycle_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_res_valid == $past(com && i_issue.op != SBAS_OP_NONE))
        else $error("result valid timing wrong");
    hold_res_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !(com && is_half) |=> $stable(o_res))
        else $error("result changed without commit");

    vec_add_c: cover property (@(posedge i_clk) com && i_issue.op == SBAS_OP_VEC_ADD);
    hadd_c: cover property (@(posedge i_clk) com && i_issue.op == SBAS_OP_HADD);
    hsub_c: cover property (@(posedge i_clk) com && i_issue.op == SBAS_OP_HSUB);
    load_c: cover property (@(posedge i_clk) i_mem_load ##1 com && i_issue.op == SBAS_OP_VEC_ADD);
endmodule
`default_nettype wire

// >>> sim/sbas_host.sv
`default_nettype none
module sbas_host
    import sbas_pkg::*;
(
    input  wire logic             i_clk,
    output var sbas_issue_type    o_issue,
    output logic                  o_commit,
    output logic                  o_load,
    output logic [VREG_AW-1:0]    o_reg,
    output logic [VREG_WIDTH-1:0] o_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_issue = '0;
        o_commit = 1'b0;
        o_load = 1'b0;
        o_reg = '0;
        o_data = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Held to the taking edge, left up so calls run back to back
    task automatic op(input sbas_op_type k, input logic c, input logic [2:0] d, s, t,
                      input logic [31:0] a, b);
        o_issue = '{1'b1, k, d, s, t, a, b};
        o_commit = c;
        o_load = 1'b0;
        o_data = ~o_data;
        @(posedge i_clk);
        #1;
    endtask
    // One beat per whole vector; idle data toggles so stale values never match
    task automatic move(input logic ld, input logic [2:0] r, input logic [63:0] v);
        o_issue.valid = 1'b0;
        o_commit = 1'b0;
        o_load = ld;
        o_reg = r;
        o_data = ld ? v : ~o_data;
        @(posedge i_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`default_nettype none
module tb_top
    import sbas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                    i_clk;
    logic                    i_rst;
    sbas_issue_type          issue;
    logic                    commit;
    logic                    load;
    logic [VREG_AW-1:0]      mreg;
    logic [VREG_WIDTH-1:0]   rdata;
    logic [VREG_WIDTH-1:0]   wdata;
    logic [VREG_WIDTH-1:0]   vsum;
    logic [VREG_WIDTH-1:0]   v0;
    logic [VREG_WIDTH-1:0]   v1;
    logic [SCALAR_WIDTH-1:0] res;
    logic [SCALAR_WIDTH-1:0] a;
    logic [SCALAR_WIDTH-1:0] b;
    logic                    res_valid;
    int                      n_fail = 0;
    int                      check_count = 0;
    sbas_top #(.MEM_WIDTH(64)) i_sbas_top (.i_clk(i_clk), .i_rst(i_rst), .i_issue(issue),
        .i_commit(commit), .i_mem_load(load), .i_mem_reg(mreg), .i_mem_rdata(rdata),
        .o_mem_wdata(wdata), .o_res(res), .o_res_valid(res_valid), .o_vsum(vsum));
    sbas_host i_sbas_host (.i_clk(i_clk), .o_issue(issue), .o_commit(commit),
        .o_load(load), .o_reg(mreg), .o_data(rdata));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [63:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Lane sums wrap inside each byte
    function automatic logic [63:0] lanes(input logic [63:0] x, y);
        for (int i = 0; i < 8; i++) lanes[8*i+:8] = x[8*i+:8] + y[8*i+:8];
    endfunction
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        i_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        check("valid_rst", res_valid, 0);
        check("vsum_rst", vsum, VREG_RESET);
        check("res_rst", res, RES_RESET);
        $display("reset done");
    endtask
    task automatic test_regfile;
        for (int i = 0; i < 8; i++) begin
            i_sbas_host.move(1'b1, 3'(i), 64'h0123456789abcdef ^ {8{8'(i)}});
        end
        for (int i = 0; i < 8; i++) begin
            i_sbas_host.move(1'b0, 3'(i), '0);
            check("vreg", wdata, 64'h0123456789abcdef ^ {8{8'(i)}});
        end
        $display("regfile done");
    endtask
    task automatic test_vec_add;
        v0 = 64'h80ff7f0001fe10c3;
        v1 = 64'h8001810aff02f04d;
        i_sbas_host.move(1'b1, 3'h0, v0);
        i_sbas_host.move(1'b1, 3'h1, v1);
        // Second add reads the first one's result, no bypass
        i_sbas_host.op(SBAS_OP_VEC_ADD, 1'b1, 3'h0, 3'h0, 3'h1, '0, '0);
        check("vsum1", vsum, lanes(v0, v1));
        check("valid", res_valid, 1);
        i_sbas_host.op(SBAS_OP_VEC_ADD, 1'b1, 3'h3, 3'h0, 3'h1, '0, '0);
        check("vsum2", vsum, lanes(lanes(v0, v1), v1));
        i_sbas_host.move(1'b0, 3'h3, '0);
        check("vdst", wdata, lanes(lanes(v0, v1), v1));
        check("pulse", res_valid, 0);
        $display("vector_byte_add done");
    endtask
    task automatic test_halfword;
        for (int i = 0; i < 2; i++) begin
            a = i ? 32'hffff0001 : 32'h7fff8000;
            b = i ? 32'h00010002 : 32'h0001ffff;
            i_sbas_host.op(SBAS_OP_HADD, 1'b1, 3'h0, 3'h0, 3'h0, a, b);
            check("hadd", res, {a[31:16] + b[31:16], a[15:0] + b[15:0]});
            i_sbas_host.op(SBAS_OP_HSUB, 1'b1, 3'h0, 3'h0, 3'h0, a, b);
            check("hsub", res, {a[31:16] - b[31:16], a[15:0] - b[15:0]});
        end
        $display("halfword done");
    endtask
    task automatic test_refuse;
        i_sbas_host.op(SBAS_OP_HADD, 1'b0, 3'h0, 3'h0, 3'h0, 32'h1, 32'h1);
        i_sbas_host.op(SBAS_OP_NONE, 1'b1, 3'h0, 3'h0, 3'h0, 32'h1, 32'h1);
        check("hold", res, {a[31:16] - b[31:16], a[15:0] - b[15:0]});
        check("nopulse", res_valid, 0);
        $display("refuse done");
    endtask
    initial begin
        test_reset();
        test_regfile();
        test_vec_add();
        test_halfword();
        test_refuse();
        tally_and_finish();
    end
endmodule
`default_nettype wire
